// file: dv/wrpc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// block bench: pins move at the falling edge, outputs are read there too
module wrpc_ctrl_tb;
   import wrpc_pkg::*;
   localparam int BIAS = 40;         // shortened counts, expectations follow them
   localparam int PRIO = 30;
   localparam int STD = 60;
   localparam int STEADY = 400;
   localparam int FAST = 200;
   localparam int HB = 4;
   // condition masks and the reason each must produce
   localparam logic [7:0] MASKS [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h18, 8'h04, 8'h02, 8'h01};
   localparam logic [7:0] RSNS [8] = '{8'h02, 8'h03, 8'h03, 8'h01, 8'h01, 8'h08, 8'h00, 8'h01};
   logic mclk, rst, select_in_a, select_in_b, adapter_over_3v6, internal_fault, hot_cmp, cold_cmp;
   logic ctrl_over_100mv, rectifier_voltage_ok, rectifier_converged, converge_timeout, large_transient;
   logic output_current_limit, ctrl_drv, pin_low, charge_status_n, charge_status_oe, ldo_enable;
   logic modulation_switch_a, modulation_switch_b, rectifier_tracking, comm_ilim_en, temp_bias_window;
   logic sense_bias_oe, ctrl_request, end_transfer_packet, frame_start;
   logic [15:0] load_current_ma, vout_mv, error_payload, rectifier_target, comm_ilim_ma, word;
   logic [7:0]  packet_header, end_reason;
   wrpc_rect_e  rect_mode;
   int          error_cnt, checks_done, split_cnt, n, k;

   wrpc_ctrl #(.BIAS_CYC(BIAS), .DGL_CYC(10), .PRIO_CYC(PRIO), .STD_CYC(STD), .STEADY_CYC(STEADY),
      .FAST_CYC(FAST), .HBIT_CYC(HB)) i_dut (.mclk, .rst, .select_in_a, .select_in_b,
      .adapter_over_3v6, .internal_fault, .hot_cmp, .cold_cmp, .ctrl_over_100mv, .rectifier_voltage_ok,
      .rectifier_converged, .converge_timeout, .large_transient, .load_current_ma, .output_current_limit,
      .vout_mv, .error_payload, .charge_status_n, .charge_status_oe, .ldo_enable, .modulation_switch_a,
      .modulation_switch_b, .rect_mode, .rectifier_target, .rectifier_tracking, .comm_ilim_en,
      .comm_ilim_ma, .temp_bias_window, .sense_bias_oe, .ctrl_request, .end_transfer_packet,
      .packet_header, .end_reason);

   wrpc_tx_model #(.HBIT(HB)) i_tx (.mclk, .rst, .mod_a(modulation_switch_a),
      .mod_b(modulation_switch_b), .frame_start, .word, .split_cnt);

   // clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // sensor pin: biased network reads high, an outside driver holds it high in the gap
   always @(negedge mclk) begin
      ctrl_over_100mv <= (temp_bias_window & !pin_low) | ctrl_drv;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int c);
      repeat (c) @(negedge mclk);
   endtask : cyc

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   function automatic logic hit(input int sel);
      case (sel)
         0: return frame_start === 1'b1;
         1: return end_transfer_packet === 1'b1;
         2: return temp_bias_window === 1'b1;
         default: return temp_bias_window === 1'b0;
      endcase
   endfunction : hit

   // bounded wait for an event; c returns the cycles spent
   task automatic wait_sig(input int sel, output int c);
      c = 0;
      do begin
         @(negedge mclk);
         c++;
      end while (!hit(sel) && c < 1500);
      if (c >= 1500) begin
         error_cnt++;
         $display("[FAIL] %0t wait timed out", $time);
         report_and_stop();
      end
   endtask : wait_sig

   // main sequence
   initial begin
      {select_in_a, select_in_b, adapter_over_3v6, internal_fault, hot_cmp, cold_cmp} = '0;
      {rectifier_voltage_ok, rectifier_converged, converge_timeout, large_transient} = '0;
      {output_current_limit, ctrl_drv, pin_low} = '0;
      load_current_ma = 16'h0000;
      vout_mv = 16'h0000;
      error_payload = 16'hA5C3;
      error_cnt = 0;
      checks_done = 0;
      rst = 1'b1;
      cyc(5);
      rst = 1'b0;
      cyc(1);
      chk(16'(ldo_enable), 16'h0000);
      chk(16'(charge_status_oe), 16'h0000);
      chk(16'(rect_mode), 16'h0000);
      // rectifier mode around the 250 mA boundary
      rectifier_voltage_ok = 1'b1;
      load_current_ma = 16'h00FA;
      cyc(2);
      chk(16'(rect_mode), 16'h0001);
      load_current_ma = 16'h00FB;
      cyc(2);
      chk(16'(rect_mode), 16'h0002);
      load_current_ma = 16'h00F9;
      cyc(2);
      chk(16'(rect_mode), 16'h0001);
      rectifier_converged = 1'b1;
      cyc(2);
      chk(16'(ldo_enable), 16'h0001);
      chk(16'(charge_status_oe), 16'h0001);
      chk(16'(charge_status_n), 16'h0000);
      // sampling phases in standard rate
      wait_sig(3, n);
      wait_sig(2, n);
      wait_sig(3, n);
      chk(16'(n), 16'(BIAS));
      chk(16'(sense_bias_oe), 16'h0000);
      wait_sig(2, n);
      chk(16'(n), 16'(STD));
      // steady packet spacing and payload
      wait_sig(0, n);
      wait_sig(0, n);
      chk(16'(n), 16'(STEADY));
      cyc(2 * HB * 16 + 4);
      chk(word, 16'hA5C3);
      // fold-back tracking and the packet-time limit
      output_current_limit = 1'b1;
      vout_mv = 16'h12C0;
      cyc(2);
      chk(rectifier_target, 16'h13BA);
      chk(16'(rectifier_tracking), 16'h0001);
      wait_sig(0, n);
      chk(16'(comm_ilim_en), 16'h0001);
      chk(comm_ilim_ma, 16'h0190);
      cyc(2 * HB * 16 + 4);
      chk(16'(comm_ilim_en), 16'h0000);
      output_current_limit = 1'b0;
      wait_sig(0, n);
      chk(16'(comm_ilim_en), 16'h0000);
      chk(rectifier_target, 16'h0000);
      // transient: faster packets and the short gap
      rectifier_converged = 1'b0;
      large_transient = 1'b1;
      cyc(1);
      large_transient = 1'b0;
      wait_sig(0, n);
      wait_sig(0, n);
      wait_sig(0, n);
      chk(16'(n), 16'(FAST));
      wait_sig(2, n);
      wait_sig(3, n);
      wait_sig(2, n);
      chk(16'(n), 16'(PRIO));
      rectifier_converged = 1'b1;
      cyc(2);
      chk(16'(ldo_enable), 16'h0001);
      // a hot glitch shorter than the deglitch time is ignored
      wait_sig(2, n);
      hot_cmp = 1'b1;
      cyc(6);
      hot_cmp = 1'b0;
      k = 0;
      repeat (450) begin
         @(negedge mclk);
         if (end_transfer_packet === 1'b1) k++;
      end
      chk(16'(k), 16'h0000);
      // every reason code, one condition at a time except both selects together at i == 4
      for (int i = 0; i < 8; i++) begin
         {internal_fault, hot_cmp, cold_cmp, select_in_a, select_in_b, converge_timeout, adapter_over_3v6,
            ctrl_drv} = MASKS[i];
         wait_sig(1, n);
         chk(16'(end_reason), 16'(RSNS[i]));
         chk(16'(packet_header), 16'h0002);
         cyc(2 * HB * 16 + 4);
         chk(word, {8'h02, RSNS[i]});
         if (i == 4) chk(16'(ldo_enable), 16'h0000);
         {internal_fault, hot_cmp, cold_cmp, select_in_a, select_in_b, converge_timeout, adapter_over_3v6,
            ctrl_drv} = '0;
         cyc(300);
      end
      pin_low = 1'b1;
      wait_sig(1, n);
      chk(16'(end_reason), 16'h0003);
      chk(16'(split_cnt), 16'h0000);
      report_and_stop();
   end
endmodule : wrpc_ctrl_tb
`default_nettype wire

// file: dv/wrpc_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
// transmitter pad side: decodes the bi-phase load modulation
// passive receiver, so it has no answer path of its own
module wrpc_tx_model #(
   parameter int HBIT = 4,           // cycles per half bit
   parameter int BITS = 16           // bits per packet
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        mod_a,
   input  wire logic        mod_b,
   output logic             frame_start,  // pulse on the first flip of a frame
   output logic [15:0]      word,         // last decoded packet, msb first
   output int               split_cnt     // cycles with the two switches apart
);
   logic prev_q;                     // line as seen one edge ago
   logic half_q;                     // first half sample of a bit
   logic busy_q;                     // inside a frame
   int   cnt_q;                      // edges since frame start

   // decode: a bit is one when the line flips in mid-bit
   always_ff @(posedge mclk) begin
      frame_start <= 1'b0;
      prev_q      <= mod_a;
      if (rst) begin
         busy_q    <= 1'b0;
         split_cnt <= 0;
      end else if (!busy_q) begin
         // the flip at the first bit start marks the frame start
         if (mod_a !== prev_q) begin
            busy_q      <= 1'b1;
            cnt_q       <= 1;
            frame_start <= 1'b1;
         end
      end else begin
         cnt_q <= cnt_q + 1;
         // sample mid-way through each half so edges never race
         if (cnt_q % (2 * HBIT) == HBIT / 2) begin
            half_q <= mod_a;
         end
         if (cnt_q % (2 * HBIT) == HBIT + HBIT / 2) begin
            word <= {word[14:0], half_q != mod_a};
         end
         if (cnt_q == 2 * HBIT * BITS) begin
            busy_q <= 1'b0;
         end
      end
      // both switches must load the coil together
      if (!rst && mod_a !== mod_b) begin
         split_cnt <= split_cnt + 1;
      end
   end
endmodule : wrpc_tx_model
`default_nettype wire

// file: hw/wrpc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - end-transfer packets carry header 0x02
// - adapter sense gives 0x00 while select B low, fault 0x02
// - control request or select A gives 0x01
// - unconverged rectifier target gives 0x08
// - status output on while output enabled
// - output held off until no-load convergence
// - both modulation switches move together
// - diode-only rectification during startup
// - half-synchronous at or below 250mA after lockout
// - full synchronous above 250mA
// - current limit sets target to output+250mV
// - 400mA limit during each packet
// - comm limit only in current-limit mode
// - bias window asserted 24ms per cycle
// - hot and cold deglitched 10ms
// - bias pin released after window
// - unbiased interval 35ms or 235ms, compare 100mV
// - level above 100mV registers control request
// - error packets every 250ms steady
// - 32ms packet interval during transients
// - bi-phase coding at 2 kbps
// - both selects high disables output
module wrpc_ctrl
   import wrpc_pkg::*;
#(
   parameter int BIAS_CYC   = wrpc_pkg::BIAS_WINDOW_CYC,
   parameter int DGL_CYC    = wrpc_pkg::DEGLITCH_CYC,
   parameter int PRIO_CYC   = wrpc_pkg::PRIO_GAP_CYC,
   parameter int STD_CYC    = wrpc_pkg::STD_GAP_CYC,
   parameter int STEADY_CYC = wrpc_pkg::STEADY_PERIOD_CYC,
   parameter int FAST_CYC   = wrpc_pkg::FAST_PERIOD_CYC,
   parameter int HBIT_CYC   = wrpc_pkg::HALF_BIT_CYC,
   parameter int PKT_BITS   = 16
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        select_in_a,           // pin, synchronised
   input  wire logic        select_in_b,           // pin, synchronised
   input  wire logic        adapter_over_3v6,      // comparator, synchronised
   input  wire logic        internal_fault,        // same-domain fault level
   input  wire logic        hot_cmp,               // comparator, synchronised
   input  wire logic        cold_cmp,              // comparator, synchronised
   input  wire logic        ctrl_over_100mv,       // pin comparator, synchronised
   input  wire logic        rectifier_voltage_ok,  // above undervoltage_lockout
   input  wire logic        rectifier_converged,   // target reached
   input  wire logic        converge_timeout,      // target failed to converge
   input  wire logic        large_transient,       // load step seen
   input  wire logic [15:0] load_current_ma,
   input  wire logic        output_current_limit,  // output at its limit
   input  wire logic [15:0] vout_mv,
   input  wire logic [15:0] error_payload,         // error packet contents
   output logic             charge_status_n,       // open-drain low level
   output logic             charge_status_oe,      // high while pulling down
   output logic             ldo_enable,
   output logic             modulation_switch_a,
   output logic             modulation_switch_b,
   output wrpc_pkg::wrpc_rect_e rect_mode,
   output logic [15:0]      rectifier_target,
   output logic             rectifier_tracking,
   output logic             comm_ilim_en,
   output logic [15:0]      comm_ilim_ma,
   output logic             temp_bias_window,
   output logic             sense_bias_oe,
   output logic             ctrl_request,
   output logic             end_transfer_packet,   // one-cycle pulse at packet start
   output logic [7:0]       packet_header,
   output logic [7:0]       end_reason
);
   import wrpc_pkg::*;

   initial begin
      if (PKT_BITS < 1 || PKT_BITS > 16 || BIAS_CYC <= DGL_CYC || HBIT_CYC < 1 || PRIO_CYC <= TS_SETTLE_CYC) begin
         $error("wrpc_ctrl: bad parameters");
      end
   end

   logic sel_a, sel_b, adp, hot, cold, ctl;   // synchronised pins

   wrpc_sync u_sa (.mclk(mclk), .rst(rst), .din(select_in_a),      .dout(sel_a));
   wrpc_sync u_sb (.mclk(mclk), .rst(rst), .din(select_in_b),      .dout(sel_b));
   wrpc_sync u_ad (.mclk(mclk), .rst(rst), .din(adapter_over_3v6), .dout(adp));
   wrpc_sync u_ho (.mclk(mclk), .rst(rst), .din(hot_cmp),          .dout(hot));
   wrpc_sync u_co (.mclk(mclk), .rst(rst), .din(cold_cmp),         .dout(cold));
   wrpc_sync u_ct (.mclk(mclk), .rst(rst), .din(ctrl_over_100mv),  .dout(ctl));

   // ---- output enable and status ----
   logic conv_seen_q;   // no-load convergence latched

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_seen_q <= 1'b0;
      end else if (rectifier_converged) begin
         conv_seen_q <= 1'b1;
      end
   end

   logic temp_fault_q;   // deglitched temperature fault
   logic stop_q;         // end-transfer condition present
   logic ldo_d;

   // output only after convergence, never with both selects high
   assign ldo_d = conv_seen_q && !(sel_a && sel_b) && !stop_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         ldo_enable       <= 1'b0;
         charge_status_n  <= 1'b0;
         charge_status_oe <= 1'b0;
      end else begin
         ldo_enable       <= ldo_d;
         charge_status_n  <= 1'b0;
         charge_status_oe <= ldo_d;
      end
   end

   // ---- rectifier mode ----
   always_ff @(posedge mclk) begin
      if (rst) begin
         rect_mode <= WRPC_RECT_DIODE;
      end else if (!rectifier_voltage_ok) begin
         rect_mode <= WRPC_RECT_DIODE;
      end else if (load_current_ma > SYNC_THRESH_MA) begin
         rect_mode <= WRPC_RECT_FULL;
      end else begin
         rect_mode <= WRPC_RECT_HALF;
      end
   end

   // ---- fold-back tracking and comm limit ----
   logic sending_q;   // packet in flight

   always_ff @(posedge mclk) begin
      if (rst) begin
         rectifier_tracking <= 1'b0;
         rectifier_target   <= 16'h0000;
         comm_ilim_en       <= 1'b0;
         comm_ilim_ma       <= 16'h0000;
      end else begin
         rectifier_tracking <= output_current_limit;
         // target follows output plus offset while limited
         rectifier_target   <= output_current_limit ? 16'(vout_mv + TRACK_OFFSET_MV) : 16'h0000;
         // limit only while limited and sending
         comm_ilim_en       <= output_current_limit && sending_q;
         comm_ilim_ma       <= COMM_ILIM_MA;
      end
   end

   // ---- temperature sense sequencing ----
   wrpc_ts_e   ts_q;
   logic [31:0] ts_cnt_q;
   logic [31:0] hot_cnt_q, cold_cnt_q;
   logic        fast_q;   // fast packet rate selected
   logic        ctl_fault_q;
   logic        gap_end;   // last cycle of the unbiased gap

   // gap length chosen by current packet rate
   assign gap_end = (ts_cnt_q >= 32'((fast_q ? PRIO_CYC : STD_CYC) - 1));

   // window and gap alternate forever
   always_ff @(posedge mclk) begin
      if (rst) begin
         ts_q     <= WRPC_SENSE_BIAS_PIN;
         ts_cnt_q <= 32'h00000000;
      end else begin
         case (ts_q)
            WRPC_SENSE_BIAS_PIN: begin
               if (ts_cnt_q == 32'(BIAS_CYC - 1)) begin
                  ts_q     <= WRPC_TS_UNBIAS;
                  ts_cnt_q <= 32'h00000000;
               end else begin
                  ts_cnt_q <= ts_cnt_q + 32'h00000001;
               end
            end
            WRPC_TS_UNBIAS: begin
               if (gap_end) begin
                  ts_q     <= WRPC_SENSE_BIAS_PIN;
                  ts_cnt_q <= 32'h00000000;
               end else begin
                  ts_cnt_q <= ts_cnt_q + 32'h00000001;
               end
            end
            default: begin
               ts_q     <= WRPC_SENSE_BIAS_PIN;
               ts_cnt_q <= 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         temp_bias_window <= 1'b0;
         sense_bias_oe    <= 1'b0;
      end else begin
         temp_bias_window <= (ts_q == WRPC_SENSE_BIAS_PIN);
         sense_bias_oe    <= (ts_q == WRPC_SENSE_BIAS_PIN);
      end
   end

   // hot/cold deglitch counters, only counted inside the window
   always_ff @(posedge mclk) begin
      if (rst) begin
         hot_cnt_q    <= 32'h00000000;
         cold_cnt_q   <= 32'h00000000;
         temp_fault_q <= 1'b0;
      end else if (ts_q == WRPC_SENSE_BIAS_PIN) begin
         hot_cnt_q  <= hot  ? (hot_cnt_q  < 32'(DGL_CYC) ? hot_cnt_q  + 32'h00000001 : hot_cnt_q)  : 32'h00000000;
         cold_cnt_q <= cold ? (cold_cnt_q < 32'(DGL_CYC) ? cold_cnt_q + 32'h00000001 : cold_cnt_q) : 32'h00000000;
         if (hot_cnt_q == 32'(DGL_CYC) || cold_cnt_q == 32'(DGL_CYC)) begin
            temp_fault_q <= 1'b1;
         end else if (ts_cnt_q == 32'(BIAS_CYC - 1)) begin
            temp_fault_q <= 1'b0;   // cleared when a clean window completes
         end
      end else begin
         hot_cnt_q  <= 32'h00000000;
         cold_cnt_q <= 32'h00000000;
      end
   end

   // gap samples skip the settling of the released pin; the request is
   // decided at gap end and stands a full cycle so no launch misses it
   logic ctl_seen_q;   // pin seen high in this gap

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_request <= 1'b0;
         ctl_seen_q   <= 1'b0;
         ctl_fault_q  <= 1'b0;
      end else if (ts_q == WRPC_TS_UNBIAS) begin
         if (gap_end) begin
            ctrl_request <= ctl_seen_q || ctl;
            ctl_seen_q   <= 1'b0;
         end else if (ctl && ts_cnt_q >= 32'(TS_SETTLE_CYC)) begin
            ctl_seen_q <= 1'b1;
         end
      end else if (ts_cnt_q == 32'(BIAS_CYC - 1)) begin
         ctl_fault_q <= !ctl;   // biased pin still low
      end
   end

   // ---- reason priority ----
   logic [7:0] reason_d;
   logic       stop_d;

   always_comb begin
      stop_d   = 1'b1;
      reason_d = RSN_UNKNOWN;
      if (internal_fault) begin
         reason_d = RSN_INTERNAL_FAULT;
      end else if (temp_fault_q || ctl_fault_q) begin
         reason_d = RSN_OVER_TEMP;
      end else if (ctrl_request || sel_a) begin
         reason_d = RSN_CHARGE_DONE;
      end else if (converge_timeout) begin
         reason_d = RSN_NO_RESPONSE;
      end else if (adp && !sel_b) begin
         reason_d = RSN_UNKNOWN;
      end else begin
         stop_d   = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stop_q     <= 1'b0;
         end_reason <= RSN_UNKNOWN;
      end else begin
         stop_q     <= stop_d;
         end_reason <= reason_d;
      end
   end

   // ---- packet scheduling ----
   logic [31:0] per_cnt_q;

   always_ff @(posedge mclk) begin
      if (rst) begin
         fast_q <= 1'b0;
      end else if (large_transient) begin
         fast_q <= 1'b1;
      end else if (rectifier_converged) begin
         fast_q <= 1'b0;
      end
   end

   logic launch;
   assign launch = (per_cnt_q >= 32'((fast_q ? FAST_CYC : STEADY_CYC) - 1));

   always_ff @(posedge mclk) begin
      if (rst) begin
         per_cnt_q <= 32'h00000000;
      end else if (launch) begin
         per_cnt_q <= 32'h00000000;
      end else begin
         per_cnt_q <= per_cnt_q + 32'h00000001;
      end
   end

   // ---- bi-phase transmitter ----
   wrpc_tx_e    tx_q;
   logic [15:0] shift_q;
   logic [4:0]  bit_q;
   logic        half_q;
   logic [31:0] hb_cnt_q;
   logic        line_q;   // modulation level

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_q                <= WRPC_TX_IDLE;
         shift_q             <= 16'h0000;
         bit_q               <= 5'h00;
         half_q              <= 1'b0;
         hb_cnt_q            <= 32'h00000000;
         line_q              <= 1'b0;
         sending_q           <= 1'b0;
         end_transfer_packet <= 1'b0;
         packet_header       <= 8'h00;
      end else begin
         end_transfer_packet <= 1'b0;
         case (tx_q)
            WRPC_TX_IDLE: begin
               if (launch) begin
                  tx_q      <= WRPC_TX_SEND;
                  sending_q <= 1'b1;
                  bit_q     <= 5'h00;
                  half_q    <= 1'b0;
                  hb_cnt_q  <= 32'h00000000;
                  line_q    <= 1'b1;   // idle is low, first bit start rises
                  if (stop_q) begin
                     packet_header       <= HDR_END_TRANSFER;
                     shift_q             <= {HDR_END_TRANSFER, end_reason};
                     end_transfer_packet <= 1'b1;
                  end else begin
                     packet_header <= 8'h00;
                     shift_q       <= error_payload;
                  end
               end
            end
            WRPC_TX_SEND: begin
               if (hb_cnt_q == 32'(HBIT_CYC - 1)) begin
                  hb_cnt_q <= 32'h00000000;
                  if (!half_q) begin
                     half_q <= 1'b1;
                     if (shift_q[15]) begin
                        line_q <= ~line_q;
                     end
                  end else begin
                     half_q  <= 1'b0;
                     shift_q <= {shift_q[14:0], 1'b0};
                     if (bit_q == 5'(PKT_BITS - 1)) begin
                        tx_q      <= WRPC_TX_IDLE;
                        sending_q <= 1'b0;
                     end else begin
                        bit_q  <= bit_q + 5'h01;
                        line_q <= ~line_q;
                     end
                  end
               end else begin
                  hb_cnt_q <= hb_cnt_q + 32'h00000001;
               end
            end
            default: begin
               tx_q      <= WRPC_TX_IDLE;
               sending_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         modulation_switch_a <= 1'b0;
         modulation_switch_b <= 1'b0;
      end else begin
         modulation_switch_a <= line_q && sending_q;
         modulation_switch_b <= line_q && sending_q;
      end
   end

   // ---- checks ----
   a_switch_pair: assert property (@(posedge mclk) disable iff (rst)
      modulation_switch_a == modulation_switch_b) else $error("switches differ");
   a_status_follow: assert property (@(posedge mclk) disable iff (rst)
      charge_status_oe == ldo_enable) else $error("status not tied to output");
   a_no_early_ldo: assert property (@(posedge mclk) disable iff (rst)
      ldo_enable |-> $past(conv_seen_q)) else $error("output before convergence");
   a_both_sel_off: assert property (@(posedge mclk) disable iff (rst)
      $past(sel_a) && $past(sel_b) |=> !ldo_enable) else $error("output with both selects");
   a_diode_start: assert property (@(posedge mclk) disable iff (rst)
      !rectifier_voltage_ok |=> rect_mode == WRPC_RECT_DIODE) else $error("sync before lockout");
   a_full_sync: assert property (@(posedge mclk) disable iff (rst)
      rectifier_voltage_ok && load_current_ma > 16'h00FA |=> rect_mode == WRPC_RECT_FULL)
      else $error("full sync missing");
   a_half_sync: assert property (@(posedge mclk) disable iff (rst)
      rectifier_voltage_ok && load_current_ma <= 16'h00FA |=> rect_mode == WRPC_RECT_HALF)
      else $error("half sync missing");
   a_track_tgt: assert property (@(posedge mclk) disable iff (rst)
      output_current_limit |=> rectifier_target == 16'($past(vout_mv) + 16'h00FA))
      else $error("tracking target wrong");
   a_comm_limit: assert property (@(posedge mclk) disable iff (rst)
      comm_ilim_en |-> $past(output_current_limit) && comm_ilim_ma == 16'h0190)
      else $error("comm limit outside limit mode");
   a_bias_pin: assert property (@(posedge mclk) disable iff (rst)
      sense_bias_oe == temp_bias_window) else $error("bias pin not released");
   a_ept_header: assert property (@(posedge mclk) disable iff (rst)
      end_transfer_packet |-> packet_header == 8'h02) else $error("bad end header");
   a_dgl_len: assert property (@(posedge mclk) disable iff (rst)
      $rose(temp_fault_q) |-> $past(hot_cnt_q) == 32'(DGL_CYC) || $past(cold_cnt_q) == 32'(DGL_CYC))
      else $error("fault before deglitch");
endmodule : wrpc_ctrl
`default_nettype wire

// file: hw/wrpc_pkg.sv
package wrpc_pkg;

   // packet header and end-transfer reason codes
   localparam logic [7:0] HDR_END_TRANSFER   = 8'h02;
   localparam logic [7:0] RSN_UNKNOWN        = 8'h00;
   localparam logic [7:0] RSN_CHARGE_DONE    = 8'h01;
   localparam logic [7:0] RSN_INTERNAL_FAULT = 8'h02;
   localparam logic [7:0] RSN_OVER_TEMP      = 8'h03;
   localparam logic [7:0] RSN_NO_RESPONSE    = 8'h08;

   // clock rate
   localparam int CLK_KHZ = 125000;

   // times as printed
   localparam int BIAS_WINDOW_MS   = 24;
   localparam int DEGLITCH_MS      = 10;
   localparam int PRIO_GAP_MS      = 35;
   localparam int STD_GAP_MS       = 235;
   localparam int STEADY_PERIOD_MS = 250;
   localparam int FAST_PERIOD_MS   = 32;
   localparam int BIT_RATE_BPS     = 2000;
   localparam int TS_SETTLE_CYC    = 8;   // released pin settling plus sync lag

   // derived cycle counts
   localparam int BIAS_WINDOW_CYC   = BIAS_WINDOW_MS * CLK_KHZ;
   localparam int DEGLITCH_CYC      = DEGLITCH_MS * CLK_KHZ;
   localparam int PRIO_GAP_CYC      = PRIO_GAP_MS * CLK_KHZ;
   localparam int STD_GAP_CYC       = STD_GAP_MS * CLK_KHZ;
   localparam int STEADY_PERIOD_CYC = STEADY_PERIOD_MS * CLK_KHZ;
   localparam int FAST_PERIOD_CYC   = FAST_PERIOD_MS * CLK_KHZ;
   // half bit period of bi-phase coding
   localparam int HALF_BIT_CYC      = (CLK_KHZ * 1000) / (2 * BIT_RATE_BPS);

   // rectifier tracking offset in millivolts
   localparam logic [15:0] TRACK_OFFSET_MV = 16'h00FA;
   // communication current limit in milliamps
   localparam logic [15:0] COMM_ILIM_MA    = 16'h0190;
   // load current boundary for full synchronous mode
   localparam logic [15:0] SYNC_THRESH_MA  = 16'h00FA;

   // rectifier modes
   typedef enum logic [1:0] {
      WRPC_RECT_DIODE = 2'b00,
      WRPC_RECT_HALF  = 2'b01,
      WRPC_RECT_FULL  = 2'b10
   } wrpc_rect_e;

   // sense sampling phases
   typedef enum logic [1:0] {
      WRPC_SENSE_BIAS_PIN   = 2'b00,
      WRPC_TS_UNBIAS = 2'b01
   } wrpc_ts_e;

   // transmitter phases
   typedef enum logic [1:0] {
      WRPC_TX_IDLE = 2'b00,
      WRPC_TX_SEND = 2'b01
   } wrpc_tx_e;

endpackage : wrpc_pkg

// file: hw/wrpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output moves only when stages two and three agree
module wrpc_sync (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic s1_q;   // metastable stage, read only by s2
   logic s2_q;   // second stage
   logic s3_q;   // third stage

   // shift chain
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // agreement filter
   always_ff @(posedge mclk) begin
      if (rst) begin
         dout <= 1'b0;
      end else if (s2_q == s3_q) begin
         dout <= s3_q;
      end
   end
endmodule : wrpc_sync
`default_nettype wire
